// [logic/scb_ctrl.sv]
// Operation
// - with the sequencer, the PLL starts by itself once the oscillator is stable
// - reference clock output stays low until the oscillator is stable
// - bit 4 at 0x59 selects an external clock on crystal pin a
// - pin five carries the reference divided by two or more, the division chosen by pin map field
// - reference clock output runs in every mode but Sleep
// - reference clock output is enabled after reset with no write
// - coarse calibration once after reset, fine calibration at each PLL start
// - synthesizer step is oscillator over two to the nineteenth, 19-bit modulator
// - carrier word is 24 bits in registers 0x07 to 0x09
// - new carrier takes effect only when the low byte is written
// - with the sequencer, receiver or transmitter starts once PLL locks
// - lock detect output goes high when PLL is in lock range
// - lock detect may drop during wide-deviation transmit; host tolerates it
// - continuous mode without shaping takes data pin bits asynchronously
// - continuous mode with shaping drives a bit clock; host syncs data
// - bit rate is oscillator over 16-bit divider from high and low byte
// - divider 0x01 0x40 gives exactly 100 kbps
`timescale 1ns/1ps
`default_nettype none
`include "scb_defs.svh"
module scb_ctrl
  import scb_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic SPI_SCK_I,
  input wire logic SPI_CS_N_I,
  input wire logic SPI_MOSI_I,
  output logic SPI_MISO_O,
  output logic SPI_MISO_OE_O,
  input wire logic SERIAL_DATA_PIN_I,
  output logic BIT_CLOCK_PIN_O,
  output logic BIT_CLOCK_PIN_OE_O,
  output logic IO_PIN_FIVE_O,
  output logic LOCK_DETECT_O,
  input wire logic OSC_STABLE_I,
  input wire logic PLL_LOCK_I,
  output logic OSC_EN_O,
  output logic XO_EXT_SEL_O,
  output logic COARSE_CAL_O,
  output logic FINE_CAL_O,
  output logic PLL_EN_O,
  output logic RX_EN_O,
  output logic TX_EN_O,
  output logic [23:0] CARRIER_WORD_O,
  output logic [5:0] SYNTH_DIV_O,
  output logic BIT_TICK_O,
  input wire logic MOD_READY_I,
  output logic TX_BIT_O,
  output logic TX_BIT_VALID_O
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_r;
  logic rst_sync_n_r;
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_meta_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [5:0] agree(input logic [5:0] a, input logic [5:0] b,
                                       input logic [5:0] f);
    agree = (~(a ^ b) & b) | ((a ^ b) & f);
  endfunction

  function automatic logic [7:0] rd_reg(input logic [6:0] a, input scb_state_s s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `SCB_A_OPMODE: v = s.opmode;
      `SCB_A_DATAMODE: v = s.datamode;
      `SCB_A_BR_HI: v = s.br_hi;
      `SCB_A_BR_LO: v = s.br_lo;
      `SCB_A_FRF_HI: v = s.frf_hi;
      `SCB_A_FRF_MID: v = s.frf_mid;
      `SCB_A_FRF_LO: v = s.frf_lo;
      `SCB_A_PINMAP2: v = s.pinmap2;
      `SCB_A_OSCSEL: v = s.oscsel;
      `SCB_A_STATUS: begin
        v[`SCB_ST_RUN] = (s.seq == SQ_RUN);
        v[`SCB_ST_LOCK] = s.filt[`SCB_IN_LOCK];
        v[`SCB_ST_CAL] = s.coarse_done;
        v[`SCB_ST_OSC] = s.filt[`SCB_IN_OSC];
      end
      default: v = 8'h00;
    endcase
    rd_reg = v;
  endfunction

  localparam scb_state_s rst_q_c = '{
    s1: `SCB_RST_IN, s2: `SCB_RST_IN, s3: `SCB_RST_IN, filt: `SCB_RST_IN,
    hdr: 1'b1, opmode: `SCB_RST_OPMODE, datamode: `SCB_RST_DATAMODE,
    br_hi: `SCB_RST_BR_HI, br_lo: `SCB_RST_BR_LO, frf_hi: `SCB_RST_FRF,
    frf_mid: `SCB_RST_FRF, frf_lo: `SCB_RST_FRF, pinmap2: `SCB_RST_PINMAP2,
    oscsel: `SCB_RST_OSCSEL, seq: SQ_POR, osc_en: 1'b1,
    br_cnt: `SCB_RST_BRCNT, default: '0};

  scb_state_s q;
  scb_state_s d;
  scb_wr_s wr;
  logic sck_rise;
  logic sck_fall;
  logic [2:0] mode;
  logic seq_on;
  logic active;
  logic osc_ok;
  logic lock;
  logic [2:0] sel;
  logic clk_ok;
  logic [19:0] sdm_sum;
  logic [15:0] div;
  logic cont;
  logic gauss;
  logic sync_tx;
  logic at_div;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic fifo_out_data;

  scb_fifo #(
    .W(1),
    .D(`SCB_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(REF_CLK_I),
    .rst_n_i(rst_sync_n_r),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  always_comb begin
    d = q;
    wr = '0;
    // ----------------------------------------
    // pin sampling, three stages
    // ----------------------------------------
    d.s1 = {PLL_LOCK_I, OSC_STABLE_I, SERIAL_DATA_PIN_I, SPI_MOSI_I, SPI_CS_N_I, SPI_SCK_I};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.filt = agree(q.s2, q.s3, q.filt);
    sck_rise = d.filt[`SCB_IN_SCK] & ~q.filt[`SCB_IN_SCK];
    sck_fall = ~d.filt[`SCB_IN_SCK] & q.filt[`SCB_IN_SCK];
    // ----------------------------------------
    // serial register port
    // ----------------------------------------
    if (d.filt[`SCB_IN_CSN]) begin
      d.bit_cnt = 3'h0;
      d.hdr = 1'b1;
      d.miso_oe = 1'b0;
    end else begin
      d.miso_oe = 1'b1;
      if (sck_rise) begin
        d.sh = {q.sh[6:0], d.filt[`SCB_IN_MOSI]};
        d.bit_cnt = q.bit_cnt + 3'h1;
        if (q.bit_cnt == `SCB_BIT_LAST) begin
          if (q.hdr) begin
            d.hdr = 1'b0;
            d.wnr = d.sh[`SCB_SPI_WNR];
            d.addr = d.sh[6:0];
            d.miso_sh = rd_reg(d.sh[6:0], q);
          end else begin
            wr.we = q.wnr;
            wr.addr = q.addr;
            wr.data = d.sh;
            d.addr = q.addr + 7'h01;
            d.miso_sh = rd_reg(d.addr, q);
          end
        end
      end else if (sck_fall) begin
        d.miso = q.miso_sh[7];
        d.miso_sh = {q.miso_sh[6:0], 1'b0};
      end
    end
    if (wr.we) begin
      case (wr.addr)
        `SCB_A_OPMODE: d.opmode = wr.data;
        `SCB_A_DATAMODE: d.datamode = wr.data;
        `SCB_A_BR_HI: d.br_hi = wr.data;
        `SCB_A_BR_LO: d.br_lo = wr.data;
        `SCB_A_FRF_HI: d.frf_hi = wr.data;
        `SCB_A_FRF_MID: d.frf_mid = wr.data;
        `SCB_A_FRF_LO: begin
          d.frf_lo = wr.data;
          d.frf_act = {q.frf_hi, q.frf_mid, wr.data};
        end
        `SCB_A_PINMAP2: d.pinmap2 = wr.data;
        `SCB_A_OSCSEL: d.oscsel = wr.data;
        default: d.opmode = q.opmode;
      endcase
    end
    // ----------------------------------------
    // start-up sequencer
    // ----------------------------------------
    mode = q.opmode[`SCB_OPM_MODE_HI:`SCB_OPM_MODE_LO];
    seq_on = ~q.opmode[`SCB_OPM_SEQOFF];
    active = (mode == `SCB_MODE_FS) || (mode == `SCB_MODE_TX) || (mode == `SCB_MODE_RX);
    osc_ok = q.filt[`SCB_IN_OSC];
    lock = q.filt[`SCB_IN_LOCK];
    d.coarse_cal = 1'b0;
    case (q.seq)
      SQ_POR: begin
        if (osc_ok) begin
          d.coarse_cal = 1'b1;
          d.coarse_done = 1'b1;
          d.seq = SQ_IDLE;
        end
      end
      SQ_IDLE: begin
        if (active && osc_ok) begin
          d.seq = seq_on ? SQ_WAIT_LOCK : SQ_RUN;
        end
      end
      SQ_WAIT_LOCK: begin
        if (!active) begin
          d.seq = SQ_IDLE;
        end else if (lock) begin
          d.seq = SQ_RUN;
        end
      end
      SQ_RUN: begin
        if (!active) begin
          d.seq = SQ_IDLE;
        end
      end
      default: d.seq = SQ_IDLE;
    endcase
    d.pll_en = (d.seq == SQ_WAIT_LOCK) || (d.seq == SQ_RUN);
    d.fine_cal = d.pll_en & ~q.pll_en;
    d.tx_en = (d.seq == SQ_RUN) && (mode == `SCB_MODE_TX);
    d.rx_en = (d.seq == SQ_RUN) && (mode == `SCB_MODE_RX);
    d.osc_en = (mode != `SCB_MODE_SLEEP) || (d.seq == SQ_POR);
    d.lock_out = lock;
    // ----------------------------------------
    // fractional divider
    // ----------------------------------------
    // 19-bit first order modulator
    sdm_sum = {1'b0, q.sdm_acc} + {1'b0, q.frf_act[`SCB_FRF_FRAC_HI:0]};
    d.sdm_acc = sdm_sum[`SCB_FRF_FRAC_HI:0];
    d.ndiv = {1'b0, q.frf_act[`SCB_FRF_MSB:`SCB_FRF_INT_LO]} + {5'h00, sdm_sum[`SCB_SDM_CARRY]};
    // ----------------------------------------
    // reference clock output
    // ----------------------------------------
    sel = q.pinmap2[`SCB_PM2_CLK_HI:`SCB_PM2_CLK_LO];
    d.clk_div = q.clk_div + 7'h01;
    clk_ok = osc_ok && (mode != `SCB_MODE_SLEEP) && (sel != `SCB_CLKSEL_OFF);
    d.clk_out = clk_ok && d.clk_div[sel];
    // ----------------------------------------
    // bit rate and data path
    // ----------------------------------------
    // divider joins both bytes
    div = {q.br_hi, q.br_lo};
    cont = q.datamode[`SCB_DM_CONT];
    gauss = q.datamode[`SCB_DM_GAUSS];
    sync_tx = cont && gauss && q.tx_en;
    at_div = (q.br_cnt >= div);
    fifo_in_valid = at_div && sync_tx && q.bclk_live;
    fifo_in_data = q.filt[`SCB_IN_DATA];
    d.tick = 1'b0;
    // count clock cycles up to divider
    if (at_div) begin
      if (!(sync_tx && !fifo_in_ready)) begin
        d.br_cnt = `SCB_RST_BRCNT;
        d.tick = 1'b1;
      end
    end else begin
      d.br_cnt = q.br_cnt + 16'h0001;
    end
    // bit clock rises per bit period
    d.bclk_oe = cont && gauss;
    if (!sync_tx) begin
      d.bclk = 1'b0;
      d.bclk_live = 1'b0;
    end else if (d.tick) begin
      d.bclk = 1'b1;
      d.bclk_live = 1'b1;
    end else if (q.br_cnt >= {1'b0, div[15:1]}) begin
      d.bclk = 1'b0;
    end
    fifo_out_ready = 1'b0;
    if (cont && !gauss) begin
      d.tx_bit = d.filt[`SCB_IN_DATA];
      d.tx_vld = q.tx_en;
    end else if (!q.tx_vld || MOD_READY_I) begin
      fifo_out_ready = 1'b1;
      d.tx_vld = fifo_out_valid;
      d.tx_bit = fifo_out_data;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      q <= rst_q_c;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign SPI_MISO_O = q.miso;
  assign SPI_MISO_OE_O = q.miso_oe;
  assign BIT_CLOCK_PIN_O = q.bclk;
  assign BIT_CLOCK_PIN_OE_O = q.bclk_oe;
  // select field resets to an enabled division
  assign IO_PIN_FIVE_O = q.clk_out;
  // raw lock follows pll, no masking
  assign LOCK_DETECT_O = q.lock_out;
  assign OSC_EN_O = q.osc_en;
  assign XO_EXT_SEL_O = q.oscsel[`SCB_OSC_EXT];
  assign COARSE_CAL_O = q.coarse_cal;
  assign FINE_CAL_O = q.fine_cal;
  assign PLL_EN_O = q.pll_en;
  assign RX_EN_O = q.rx_en;
  assign TX_EN_O = q.tx_en;
  assign CARRIER_WORD_O = q.frf_act;
  assign SYNTH_DIV_O = q.ndiv;
  assign BIT_TICK_O = q.tick;
  assign TX_BIT_O = q.tx_bit;
  assign TX_BIT_VALID_O = q.tx_vld;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [15:0] gap_r;
  logic gap_ok_r;
  always_ff @(posedge REF_CLK_I or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      gap_r <= 16'h0000;
      gap_ok_r <= 1'b0;
    end else begin
      gap_r <= BIT_TICK_O ? 16'h0001 : gap_r + 16'h0001;
      gap_ok_r <= (BIT_TICK_O | gap_ok_r) & fifo_in_ready
                  & ~(wr.we && ((wr.addr == `SCB_A_BR_HI) || (wr.addr == `SCB_A_BR_LO)));
    end
  end

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!rst_sync_n_r);

  sequence s_frf_lo_wr;
    wr.we && (wr.addr == `SCB_A_FRF_LO);
  endsequence
  sequence s_frf_up_wr;
    wr.we && ((wr.addr == `SCB_A_FRF_HI) || (wr.addr == `SCB_A_FRF_MID));
  endsequence
  sequence s_osc_wr;
    wr.we && (wr.addr == `SCB_A_OSCSEL);
  endsequence
  sequence s_clk_div2;
    (clk_ok && (sel == `SCB_CLKSEL_DIV2))[*3];
  endsequence

  chk_pll_auto_start: assert property (
    (q.seq == SQ_IDLE && seq_on && active && osc_ok) |=> PLL_EN_O && FINE_CAL_O)
    else $error("pll not started after oscillator stable");
  chk_ref_clock_output_hold: assert property (
    !osc_ok |=> !IO_PIN_FIVE_O)
    else $error("clock output active before oscillator stable");
  chk_ext_clk_sel: assert property (
    s_osc_wr |=> XO_EXT_SEL_O == $past(wr.data[`SCB_OSC_EXT]))
    else $error("external clock select not applied");
  chk_ref_clock_output_toggle: assert property (
    s_clk_div2 |-> IO_PIN_FIVE_O != $past(IO_PIN_FIVE_O))
    else $error("clock output not toggling at fastest division");
  chk_sleep_clk_off: assert property (
    (mode == `SCB_MODE_SLEEP && q.seq != SQ_POR) |=> !IO_PIN_FIVE_O && !OSC_EN_O)
    else $error("clock output or oscillator on in sleep");
  chk_coarse_once: assert property (
    $past(q.coarse_done) |-> !COARSE_CAL_O)
    else $error("coarse calibration repeated");
  chk_fine_cal_pulse: assert property (
    $rose(PLL_EN_O) |-> FINE_CAL_O ##1 !FINE_CAL_O)
    else $error("fine calibration not pulsed at pll start");
  chk_sdm_range: assert property (
    $stable(CARRIER_WORD_O) |-> (SYNTH_DIV_O == {1'b0, q.frf_act[23:19]})
      || (SYNTH_DIV_O == {1'b0, q.frf_act[23:19]} + 6'h01))
    else $error("divider outside integer and integer plus one");
  chk_frf_load: assert property (
    s_frf_lo_wr |=> CARRIER_WORD_O == {$past(q.frf_hi), $past(q.frf_mid), $past(wr.data)})
    else $error("carrier word not committed on low byte");
  chk_frf_hold: assert property (
    s_frf_up_wr |=> $stable(CARRIER_WORD_O))
    else $error("carrier changed on upper byte write");
  chk_auto_tx_run: assert property (
    (q.seq == SQ_WAIT_LOCK && lock && mode == `SCB_MODE_TX) |=> TX_EN_O ##1 !FINE_CAL_O)
    else $error("transmitter not started on lock");
  chk_lock_detect: assert property (
    lock |=> LOCK_DETECT_O)
    else $error("lock detect not raised");
  chk_async_data: assert property (
    (cont && !gauss) |=> TX_BIT_O == $past(d.filt[`SCB_IN_DATA]))
    else $error("async data not passed through");
  chk_bit_clock: assert property (
    (d.tick && sync_tx) |=> BIT_CLOCK_PIN_O && BIT_TICK_O)
    else $error("bit clock not raised with bit tick");
  chk_bit_rate_divider_value_gap: assert property (
    (BIT_TICK_O && gap_ok_r && div != 16'h0000) |-> gap_r == div)
    else $error("bit period differs from divider");
endmodule
`default_nettype wire

// [logic/scb_defs.svh]
`ifndef SCB_DEFS_SVH
`define SCB_DEFS_SVH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define SCB_A_OPMODE 7'h01
`define SCB_A_DATAMODE 7'h02
`define SCB_A_BR_HI 7'h03
`define SCB_A_BR_LO 7'h04
`define SCB_A_FRF_HI 7'h07
`define SCB_A_FRF_MID 7'h08
`define SCB_A_FRF_LO 7'h09
`define SCB_A_PINMAP2 7'h26
`define SCB_A_STATUS 7'h27
`define SCB_A_OSCSEL 7'h59
// ----------------------------------------
// reset values
// ----------------------------------------
`define SCB_RST_OPMODE 8'h04
`define SCB_RST_DATAMODE 8'h00
`define SCB_RST_BR_HI 8'h01
`define SCB_RST_BR_LO 8'h40
`define SCB_RST_FRF 8'h00
`define SCB_RST_PINMAP2 8'h00
`define SCB_RST_OSCSEL 8'h00
`define SCB_RST_IN 6'h02
`define SCB_RST_BRCNT 16'h0001
// ----------------------------------------
// field positions
// ----------------------------------------
`define SCB_OPM_SEQOFF 7
`define SCB_OPM_MODE_HI 4
`define SCB_OPM_MODE_LO 2
`define SCB_DM_CONT 6
`define SCB_DM_GAUSS 1
`define SCB_PM2_CLK_HI 2
`define SCB_PM2_CLK_LO 0
`define SCB_OSC_EXT 4
`define SCB_ST_RUN 7
`define SCB_ST_LOCK 4
`define SCB_ST_CAL 1
`define SCB_ST_OSC 0
`define SCB_SPI_WNR 7
`define SCB_FRF_MSB 23
`define SCB_FRF_INT_LO 19
`define SCB_FRF_FRAC_HI 18
`define SCB_SDM_CARRY 19
// ----------------------------------------
// input sampling positions
// ----------------------------------------
`define SCB_IN_SCK 0
`define SCB_IN_CSN 1
`define SCB_IN_MOSI 2
`define SCB_IN_DATA 3
`define SCB_IN_OSC 4
`define SCB_IN_LOCK 5
// ----------------------------------------
// codes and counts
// ----------------------------------------
`define SCB_MODE_SLEEP 3'h0
`define SCB_MODE_STDBY 3'h1
`define SCB_MODE_FS 3'h2
`define SCB_MODE_TX 3'h3
`define SCB_MODE_RX 3'h4
`define SCB_CLKSEL_DIV2 3'h0
`define SCB_CLKSEL_OFF 3'h7
`define SCB_BIT_LAST 3'h7
`define SCB_FIFO_DEPTH 8
`endif

// [logic/scb_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module scb_fifo #(
  parameter int unsigned W = 1,
  parameter int unsigned D = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } scb_fifo_q_s;
  scb_fifo_q_s q;
  scb_fifo_q_s d;
  logic full;
  logic empty;
  always_comb begin
    full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
    empty = (q.wp == q.rp);
    d = q;
    if (in_valid_i && !full) begin
      d.mem[q.wp[AW-1:0]] = in_data_i;
      d.wp = q.wp + 1'b1;
    end
    if (out_ready_i && !empty) begin
      d.rp = q.rp + 1'b1;
    end
  end
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = q.mem[q.rp[AW-1:0]];
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// [logic/scb_pkg.sv]
`default_nettype none
package scb_pkg;
  typedef enum logic [1:0] {SQ_POR, SQ_IDLE, SQ_WAIT_LOCK, SQ_RUN} scb_seq_e;
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } scb_wr_s;
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] filt;
    logic [2:0] bit_cnt;
    logic hdr;
    logic wnr;
    logic [6:0] addr;
    logic [7:0] sh;
    logic [7:0] miso_sh;
    logic miso;
    logic miso_oe;
    logic [7:0] opmode;
    logic [7:0] datamode;
    logic [7:0] br_hi;
    logic [7:0] br_lo;
    logic [7:0] frf_hi;
    logic [7:0] frf_mid;
    logic [7:0] frf_lo;
    logic [7:0] pinmap2;
    logic [7:0] oscsel;
    logic [23:0] frf_act;
    scb_seq_e seq;
    logic coarse_done;
    logic coarse_cal;
    logic fine_cal;
    logic pll_en;
    logic osc_en;
    logic tx_en;
    logic rx_en;
    logic [18:0] sdm_acc;
    logic [5:0] ndiv;
    logic [6:0] clk_div;
    logic clk_out;
    logic [15:0] br_cnt;
    logic tick;
    logic bclk;
    logic bclk_oe;
    logic bclk_live;
    logic tx_bit;
    logic tx_vld;
    logic lock_out;
  } scb_state_s;
endpackage
`default_nettype wire

// [test/scb_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module scb_ctrl_bench;
  import scb_pkg::*;
  logic clk, rstn, sck, csn, mosi, miso, dpin, bclk, bclk_oe, io5, lockd, osc, lock;
  logic xsel, cc, fc, pll, tx, tick, mrdy, txb, txv, moe, rxe, osce;
  logic [5:0] sdiv;
  logic [23:0] cw;
  logic [7:0] rdv, rx_w;
  int fails, num_checks, cyc, last, per, ck5_n, coarse_n, fine_n, tick_n, a;
  scb_ctrl scb_ctrl_inst (.REF_CLK_I(clk), .RSTN_I(rstn), .SPI_SCK_I(sck),
    .SPI_CS_N_I(csn), .SPI_MOSI_I(mosi), .SPI_MISO_O(miso), .SPI_MISO_OE_O(moe),
    .SERIAL_DATA_PIN_I(dpin), .BIT_CLOCK_PIN_O(bclk), .BIT_CLOCK_PIN_OE_O(bclk_oe),
    .IO_PIN_FIVE_O(io5), .LOCK_DETECT_O(lockd), .OSC_STABLE_I(osc), .PLL_LOCK_I(lock),
    .OSC_EN_O(osce), .XO_EXT_SEL_O(xsel), .COARSE_CAL_O(cc), .FINE_CAL_O(fc), .PLL_EN_O(pll),
    .RX_EN_O(rxe), .TX_EN_O(tx), .CARRIER_WORD_O(cw), .SYNTH_DIV_O(sdiv), .BIT_TICK_O(tick),
    .MOD_READY_I(mrdy), .TX_BIT_O(txb), .TX_BIT_VALID_O(txv));
  scb_host_model scb_host_model_inst (.clk_i(clk), .sck_o(sck), .cs_n_o(csn),
    .mosi_o(mosi), .miso_i(miso), .data_o(dpin), .bclk_i(bclk), .bclk_oe_i(bclk_oe));
  // ----------------------------------------
  // clock, monitors, helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  logic p5;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    p5 <= io5;
    if (io5 && !p5) ck5_n <= ck5_n + 1;
    if (cc) coarse_n <= coarse_n + 1;
    if (fc) fine_n <= fine_n + 1;
    if (txv && mrdy) rx_w <= {rx_w[6:0], txb};
    if (tick) begin
      tick_n <= tick_n + 1;
      per <= cyc - last;
      last <= cyc;
    end
  end
  task automatic cmp(input logic [23:0] g, input logic [23:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    scb_host_model_inst.spi({1'b1, ad}, d, rdv);
    repeat (8) @(negedge clk);
  endtask
  task automatic rd(input logic [6:0] ad);
    scb_host_model_inst.spi({1'b0, ad}, 8'h00, rdv);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_boot;
    wt(20);
    cmp(ck5_n, 0); // no clock before oscillator stable
    osc = 1'b1;
    wt(40);
    cmp(coarse_n, 1); // one coarse calibration
    a = ck5_n;
    wt(40);
    cmp(ck5_n - a, 20); // clock output on by default
    wr(7'h26, 8'h01);
    a = ck5_n;
    wt(40);
    cmp(ck5_n - a, 10); // divided output
    wr(7'h26, 8'h07);
    a = ck5_n;
    wt(40);
    cmp(ck5_n - a, 0); // output off
    wr(7'h26, 8'h00);
    $display("boot done");
  endtask
  task automatic t_regs;
    rd(7'h03);
    cmp(rdv, 8'h01); // divider high byte
    rd(7'h04);
    cmp(rdv, 8'h40); // divider low byte
    rd(7'h59);
    cmp(rdv, 8'h00); // internal oscillator default
    rd(7'h30);
    cmp(rdv, 8'h00); // unmapped address reads zero
    cmp(moe, 1'b0); // data out released after access
    wr(7'h59, 8'h10);
    cmp(xsel, 1'b1); // external clock select
    wr(7'h59, 8'h00);
    cmp(xsel, 1'b0); // back to crystal
    wr(7'h07, 8'h12);
    wr(7'h08, 8'h34);
    cmp(cw, 24'h000000); // upper bytes alone
    wr(7'h09, 8'h56);
    cmp(cw, 24'h123456); // full word committed
    cmp(sdiv >> 1, 6'h01); // divider is integer part of carrier word or one above
    wr(7'h07, 8'hab);
    cmp(cw, 24'h123456); // held until low byte
    $display("regs done");
  endtask
  task automatic t_seq;
    a = fine_n;
    wr(7'h01, 8'h0c);
    cmp(pll, 1'b1); // pll started by itself
    cmp(fine_n - a, 1); // fine calibration per start
    cmp(tx, 1'b0); // no transmit before lock
    lock = 1'b1;
    for (int i = 0; i < 20 && lockd !== 1'b1; i++) wt(1);
    cmp(lockd, 1'b1); // lock detect high
    wt(2);
    cmp(tx, 1'b1); // transmitter after lock
    lock = 1'b0;
    wt(8);
    cmp(lockd, 1'b0); // false unlock allowed
    cmp(tx, 1'b1); // transmit keeps running
    lock = 1'b1;
    wt(8);
    $display("seq done");
  endtask
  task automatic t_stream;
    logic [15:0] p2;
    logic ok;
    p2 = 16'hb2b2;
    ok = 1'b0;
    wr(7'h02, 8'h42);
    cmp(bclk_oe, 1'b1); // bit clock driven
    wt(700);
    cmp(per, 320); // divider 0x0140 period
    wr(7'h03, 8'h00);
    wr(7'h04, 8'h10);
    wt(40);
    cmp(per, 16); // period equals divider
    mrdy = 1'b0;
    wt(300);
    a = tick_n;
    wt(100);
    cmp(tick_n - a, 0); // full buffer stalls bit clock
    mrdy = 1'b1;
    wt(400);
    for (int r = 0; r < 8; r++) if (rx_w === 8'(p2 >> r)) ok = 1'b1;
    cmp(ok, 1'b1); // bits delivered in order
    $display("stream done");
  endtask
  task automatic t_async;
    wr(7'h02, 8'h40);
    cmp(bclk_oe, 1'b0); // no bit clock unshaped
    // data fed with no bit clock
    scb_host_model_inst.data_o = 1'b1;
    wt(8);
    cmp({txv, txb}, 2'b11); // bit passes through
    scb_host_model_inst.data_o = 1'b0;
    wt(8);
    cmp({txv, txb}, 2'b10); // bit passes through
    $display("async done");
  endtask
  task automatic t_sleep;
    wr(7'h01, 8'h00);
    a = ck5_n;
    wt(40);
    cmp(ck5_n - a, 0); // clock output off in sleep
    cmp(pll, 1'b0); // synthesizer off in sleep
    cmp(osce, 1'b0); // oscillator off in sleep
    wr(7'h01, 8'h04);
    a = ck5_n;
    wt(40);
    cmp(ck5_n - a, 20); // back in standby
    wr(7'h01, 8'h10);
    cmp({pll, rxe, tx}, 3'b110); // receiver started on lock
    wr(7'h01, 8'h04);
    lock = 1'b0;
    wr(7'h01, 8'h90);
    cmp({pll, rxe, lockd}, 3'b110); // manual start, host watches lock
    $display("sleep done");
  endtask
  initial begin
    {rstn, osc, lock, mrdy, p5, rx_w} = '0;
    {fails, num_checks, cyc, last, per, ck5_n, coarse_n, fine_n, tick_n} = '0;
    mrdy = 1'b1;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    t_boot();
    t_regs();
    t_seq();
    t_stream();
    t_async();
    t_sleep();
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire

// [test/scb_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scb_host_model (
  input wire logic clk_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  output logic data_o,
  input wire logic bclk_i,
  input wire logic bclk_oe_i
);
  logic [7:0] pat;
  int idx;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    data_o = 1'b0;
    pat = 8'hb2;
    idx = 0;
  end
  // next bit presented after each bit clock rise
  initial begin
    forever begin
      @(posedge bclk_i);
      @(negedge clk_i);
      if (bclk_oe_i) begin
        data_o = pat[7 - (idx % 8)];
        idx = idx + 1;
      end
    end
  end
  // ----------------------------------------
  // serial access, header then one data byte
  // ----------------------------------------
  task automatic spi(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {hdr, wd};
    rd = 8'h00;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o = sh[i];
      repeat (12) @(negedge clk_i);
      if (i < 8) rd[i] = miso_i;
      sck_o = 1'b1;
      repeat (12) @(negedge clk_i);
      sck_o = 1'b0;
    end
    repeat (12) @(negedge clk_i);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    repeat (12) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire
